//--- mpss_cfg.svh
// Timing counts and reset values for the module power-state sequencer
`ifndef MPSS_CFG_SVH
`define MPSS_CFG_SVH
`define MPSS_CLK_HZ        10000000
`define MPSS_XO_SETTLE_MS  5
`define MPSS_XO_SETTLE_CYC ((`MPSS_CLK_HZ / 1000) * `MPSS_XO_SETTLE_MS)
`define MPSS_NUM_PINS      8
`define MPSS_STATE_RST     6'h01
`endif

//--- mpss_host_model.sv
// Host sequencing model driving supply, enable and reset pins
`timescale 1ns/1ns
module mpss_host_model #(
    parameter int SETTLE_CYC = 20
) (
    input  wire logic            mclk_in,
    input  wire logic            up_in,
    input  wire logic            bad_en_in,
    input  wire logic            early_in,
    output wire mpss_pkg::mpss_pins_t pins_out
);
    int                   cnt_ff  = 0;
    int                   hold_cyc;
    mpss_pkg::mpss_pins_t pins_ff = '0;
    assign pins_out = pins_ff;
    // Early mode releases reset long before the crystal settles
    assign hold_cyc = early_in ? 2 : SETTLE_CYC;
    // supply, then enable, counted wait, then release
    always @(posedge mclk_in) begin
        if (bad_en_in) begin
            pins_ff <= 3'h2; // Enable without supply
        end else if (up_in) begin
            pins_ff.io_supply <= 1'b1; // Battery rail taken as tied to it
            pins_ff.power_enable <= pins_ff.io_supply;
            cnt_ff <= pins_ff.power_enable ? cnt_ff + 1 : 0;
            pins_ff.hard_reset_low <= cnt_ff > hold_cyc;
        end else begin
            pins_ff.power_enable <= 1'b0;
            pins_ff.hard_reset_low <= 1'b0;
            cnt_ff <= 0;
        end
    end
endmodule

//--- mpss_pad_ctrl.sv
// Per-pin digital pad control for the power-state sequencer
`timescale 1ns/1ns
module mpss_pad_ctrl #(
    parameter int NUM_PINS = 8
) (
    input  wire logic                mclk_in,
    input  wire logic                nrst_in,
    input  wire logic                core_on_in,
    input  wire logic                pull_en_in,
    input  wire logic                input_en_in,
    input  wire logic                programmed_in,
    input  wire logic [NUM_PINS-1:0] fw_oe_in,
    input  wire logic [NUM_PINS-1:0] fw_pull_in,
    output logic      [NUM_PINS-1:0] pad_oe_out,
    output logic      [NUM_PINS-1:0] pad_ie_out,
    output logic      [NUM_PINS-1:0] pad_pull_out
);
    // Refuse an empty pad bank
    if (NUM_PINS < 1) begin : g_bad_pins
        $error("NUM_PINS must be at least 1");
    end

    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i++) begin : g_pin
            wire logic nxt_oe;
            wire logic nxt_ie;
            wire logic nxt_pull;
            // Firmware owns the pin once programmed; input opposes output
            assign nxt_oe   = core_on_in & programmed_in & fw_oe_in[i];
            assign nxt_ie   = core_on_in & (programmed_in ? ~fw_oe_in[i] : input_en_in);
            assign nxt_pull = core_on_in & (programmed_in ? fw_pull_in[i] : pull_en_in);
            // Registered pad controls, all off in reset
            always_ff @(posedge mclk_in) begin
                if (!nrst_in) begin
                    pad_oe_out[i]   <= 1'b0;
                    pad_ie_out[i]   <= 1'b0;
                    pad_pull_out[i] <= 1'b0;
                end else begin
                    pad_oe_out[i]   <= nxt_oe;
                    pad_ie_out[i]   <= nxt_ie;
                    pad_pull_out[i] <= nxt_pull;
                end
            end
        end
    endgenerate
endmodule

//--- mpss_pkg.sv
// Types for the module power-state sequencer
package mpss_pkg;
    // One-hot device power states
    typedef enum logic [5:0] {
        MPSS_PWR_DOWN  = 6'h01,
        MPSS_POR       = 6'h02,
        MPSS_DEFAULT   = 6'h04,
        MPSS_DOZE      = 6'h08,
        MPSS_TX        = 6'h10,
        MPSS_RX        = 6'h20
    } mpss_state_t;

    // Host-driven pin levels
    typedef struct packed {
        logic io_supply;
        logic power_enable;
        logic hard_reset_low;
    } mpss_pins_t;

    // Radio activity request from the core
    typedef struct packed {
        logic wlan_tx_state;
        logic wlan_rx_state;
        logic short_range_tx_state;
        logic short_range_rx_state;
    } mpss_radio_t;
endpackage

//--- mpss_properties.sv
// Checker of power-state and pad relations of the sequencer
`timescale 1ns/1ns
module mpss_properties #(
    parameter int NUM_PINS   = 8,
    parameter int SETTLE_CYC = 20
) (
    input wire logic                  mclk_in,
    input wire logic                  nrst_in,
    input wire mpss_pkg::mpss_pins_t  pins_in,
    input wire mpss_pkg::mpss_radio_t radio_in,
    input wire logic                  core_on_out,
    input wire logic                  core_rst_out,
    input wire logic [5:0]            state_out,
    input wire logic [NUM_PINS-1:0]   pad_oe_out,
    input wire logic [NUM_PINS-1:0]   pad_ie_out,
    input wire logic [NUM_PINS-1:0]   pad_pull_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    // Core state and pad modes per host pins
    chk_off_pads_quiet: assert property (pins_in == 3'h4 |=>
        !core_on_out && pad_oe_out == '0 && pad_ie_out == '0 && pad_pull_out == '0)
        else $error("pads active while powered down");
    chk_reset_pulls_only: assert property (pins_in == 3'h6 |=>
        core_on_out && pad_oe_out == '0 && pad_ie_out == '0 && pad_pull_out == '1)
        else $error("pad mode wrong while held in reset");
    chk_default_inputs_on: assert property (state_out == 6'h04 |->
        pad_oe_out == '0 && &pad_ie_out && &pad_pull_out)
        else $error("pad mode wrong before programming");
    chk_core_needs_enable: assert property (
        !(pins_in.io_supply && pins_in.power_enable) |=> !core_on_out)
        else $error("core on without supply and enable");
    chk_doze_stays_idle: assert property (
        state_out == 6'h08 && pins_in == 3'h7 && radio_in == '0 |=> state_out == 6'h08
        && core_on_out && !core_rst_out && pad_ie_out == ~pad_oe_out)
        else $error("doze state not held");
    // Main scenarios reached
    cover property (state_out == 6'h10);
    cover property (state_out == 6'h20);
    cover property (state_out == 6'h08);
endmodule
bind mpss_sequencer mpss_properties #(.NUM_PINS(NUM_PINS), .SETTLE_CYC(SETTLE_CYC)) i_props (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .pins_in(pins_in), .radio_in(radio_in),
    .core_on_out(core_on_out), .core_rst_out(core_rst_out), .state_out(state_out),
    .pad_oe_out(pad_oe_out), .pad_ie_out(pad_ie_out), .pad_pull_out(pad_pull_out));

//--- mpss_sequencer.sv
// Power-state sequencer: tracks host pins, gates core power and pad modes
`timescale 1ns/1ns
`include "mpss_cfg.svh"

// Operation
// - Operating only with supply and enable.
// - Power-down: core off, pads fully off.
// - In reset: pulls on, rest off.
// - Out of reset, until firmware takes the pads in doze: inputs, pulls on.
// - Doze keeps core on, no radio.
module mpss_sequencer #(
    parameter int NUM_PINS   = `MPSS_NUM_PINS,
    parameter int SETTLE_CYC = `MPSS_XO_SETTLE_CYC
) (
    input  wire logic                 mclk_in,
    input  wire logic                 nrst_in,
    input  wire mpss_pkg::mpss_pins_t pins_in,
    input  wire mpss_pkg::mpss_radio_t radio_in,
    input  wire logic                 fw_done_in,
    input  wire logic [NUM_PINS-1:0]  fw_oe_in,
    input  wire logic [NUM_PINS-1:0]  fw_pull_in,
    output logic                      core_on_out,
    output logic                      core_rst_out,
    output logic                      xo_stable_out,
    output logic                      seq_error_out,
    output logic [5:0]                state_out,
    output logic [NUM_PINS-1:0]       pad_oe_out,
    output logic [NUM_PINS-1:0]       pad_ie_out,
    output logic [NUM_PINS-1:0]       pad_pull_out
);
    // Counter wide enough to hold the settle count
    localparam int CW = $clog2(SETTLE_CYC + 1);

    // Refuse sizes the counter or the pad bank cannot serve
    if (SETTLE_CYC < 1) begin : g_bad_settle
        $error("SETTLE_CYC must be at least 1");
    end
    if (NUM_PINS < 1) begin : g_bad_pins
        $error("NUM_PINS must be at least 1");
    end

    // State, settle count and firmware ownership
    mpss_pkg::mpss_state_t state_ff;
    mpss_pkg::mpss_state_t nxt_state;
    logic [CW-1:0]         settle_ff;
    logic [CW-1:0]         nxt_settle;
    logic                  programmed_ff;
    logic                  nxt_programmed;
    logic                  nxt_error;

    // Decoded pin conditions
    wire logic powered;
    wire logic in_reset;
    wire logic tx_req;
    wire logic rx_req;
    wire logic settled;
    assign powered  = pins_in.io_supply & pins_in.power_enable;
    assign in_reset = ~pins_in.hard_reset_low;
    // Radio requests merged per direction
    assign tx_req   = radio_in.wlan_tx_state | radio_in.short_range_tx_state;
    assign rx_req   = radio_in.wlan_rx_state | radio_in.short_range_rx_state;
    assign settled  = (settle_ff == CW'(SETTLE_CYC));

    // Current state decodes
    wire logic st_por;
    wire logic st_default;
    assign st_por     = (state_ff == mpss_pkg::MPSS_POR);
    assign st_default = (state_ff == mpss_pkg::MPSS_DEFAULT);

    // Crystal settle counter runs while core powered
    // Saturates at the settle count, so a long hold in reset cannot wrap it
    assign nxt_settle = !powered ? '0 : (settled ? settle_ff : settle_ff + CW'(1));

    wire logic err_no_supply;
    wire logic err_split_fall;
    wire logic err_early_release;
    // Enable high while the I/O supply is absent
    assign err_no_supply     = pins_in.power_enable & ~pins_in.io_supply;
    // Enable dropped alone while reset stays released
    assign err_split_fall    = ~pins_in.power_enable & pins_in.hard_reset_low
                             & pins_in.io_supply;
    // Reset released before the crystal has settled
    assign err_early_release = pins_in.hard_reset_low & pins_in.power_enable
                             & ~settled & st_por;
    assign nxt_error = seq_error_out | err_no_supply | err_split_fall | err_early_release;

    // Firmware takes the pads only on the step from default into doze
    // Any reset or power loss hands them back to the fixed pad modes
    assign nxt_programmed = powered & ~in_reset
                          & (programmed_ff | (fw_done_in & st_default));

    // State selection
    // Power loss wins over reset, reset over firmware and radio
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            mpss_pkg::MPSS_PWR_DOWN: begin
                if (powered) nxt_state = mpss_pkg::MPSS_POR;
            end
            mpss_pkg::MPSS_POR: begin
                if (!powered) nxt_state = mpss_pkg::MPSS_PWR_DOWN;
                else if (!in_reset) nxt_state = mpss_pkg::MPSS_DEFAULT;
            end
            mpss_pkg::MPSS_DEFAULT: begin
                // Firmware done moves on to doze
                if (!powered) nxt_state = mpss_pkg::MPSS_PWR_DOWN;
                else if (in_reset) nxt_state = mpss_pkg::MPSS_POR;
                else if (fw_done_in) nxt_state = mpss_pkg::MPSS_DOZE;
            end
            mpss_pkg::MPSS_DOZE, mpss_pkg::MPSS_TX, mpss_pkg::MPSS_RX: begin
                // doze when no radio activity
                // Transmit wins over receive when both ask
                if (!powered) nxt_state = mpss_pkg::MPSS_PWR_DOWN;
                else if (in_reset) nxt_state = mpss_pkg::MPSS_POR;
                else if (tx_req) nxt_state = mpss_pkg::MPSS_TX;
                else if (rx_req) nxt_state = mpss_pkg::MPSS_RX;
                else nxt_state = mpss_pkg::MPSS_DOZE;
            end
            // Illegal code falls back to power-down
            default: nxt_state = mpss_pkg::MPSS_PWR_DOWN;
        endcase
    end

    // State and counters
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            state_ff      <= mpss_pkg::mpss_state_t'(`MPSS_STATE_RST);
            settle_ff     <= '0;
            programmed_ff <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            settle_ff     <= nxt_settle;
            programmed_ff <= nxt_programmed;
        end
    end

    // Next-state decodes feeding the registered outputs
    wire logic nxt_down;
    wire logic nxt_por;
    wire logic nxt_core_on;
    wire logic nxt_core_rst;
    wire logic nxt_xo_stable;
    assign nxt_down      = (nxt_state == mpss_pkg::MPSS_PWR_DOWN);
    assign nxt_por       = (nxt_state == mpss_pkg::MPSS_POR);
    // core converter on in every powered state
    assign nxt_core_on   = ~nxt_down;
    // Core stays in reset until the host releases it
    assign nxt_core_rst  = nxt_down | nxt_por;
    // Settle flag as the counter lands on its final count
    assign nxt_xo_stable = (nxt_settle == CW'(SETTLE_CYC));

    // Core power and reset controls
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            core_on_out  <= 1'b0;
            core_rst_out <= 1'b1;
        end else begin
            core_on_out  <= nxt_core_on;
            core_rst_out <= nxt_core_rst;
        end
    end

    // Crystal status and sticky ordering fault
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            xo_stable_out <= 1'b0;
            seq_error_out <= 1'b0;
        end else begin
            xo_stable_out <= nxt_xo_stable;
            seq_error_out <= nxt_error;
        end
    end

    // Visible state code, same edge as the pad controls
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            state_out <= `MPSS_STATE_RST;
        end else begin
            state_out <= nxt_state;
        end
    end

    wire logic pad_core_on;
    wire logic pad_input_en;
    wire logic pad_pull_en;
    // pads fully off while the core is down
    assign pad_core_on  = nxt_core_on;
    // pulls on from power-on reset onward
    assign pad_pull_en  = pad_core_on;
    // input buffers on once out of reset
    assign pad_input_en = ~nxt_por;

    // Per-pin pad registers; ownership passes to firmware with the state
    // Firmware-owned modes are chosen per pin inside the pad bank
    mpss_pad_ctrl #(
        .NUM_PINS (NUM_PINS)
    ) i_mpss_pad_ctrl (
        .mclk_in       (mclk_in),
        .nrst_in       (nrst_in),
        .core_on_in    (pad_core_on),
        .pull_en_in    (pad_pull_en),
        .input_en_in   (pad_input_en),
        .programmed_in (nxt_programmed),
        .fw_oe_in      (fw_oe_in),
        .fw_pull_in    (fw_pull_in),
        .pad_oe_out    (pad_oe_out),
        .pad_ie_out    (pad_ie_out),
        .pad_pull_out  (pad_pull_out)
    );
endmodule

//--- mpss_sequencer_bench.sv
// Testbench of the power-state sequencer with a host model
`timescale 1ns/1ns
module mpss_sequencer_bench;
    localparam int SC = 20;
    logic                  mclk_in, nrst_in, up, bad, fw_done, core_on, core_rst, xo_ok, err;
    logic                  early;
    logic [5:0]            state;
    logic [7:0]            fw_oe, fw_pull, oe, ie, pull;
    mpss_pkg::mpss_radio_t radio;
    mpss_pkg::mpss_pins_t  pins;
    int                    mismatches = 0, checks = 0, cyc = 0;
    mpss_host_model #(.SETTLE_CYC(SC)) i_mpss_host_model (.mclk_in(mclk_in), .up_in(up),
        .bad_en_in(bad), .early_in(early), .pins_out(pins));
    mpss_sequencer #(.NUM_PINS(8), .SETTLE_CYC(SC)) i_mpss_sequencer (.mclk_in(mclk_in),
        .nrst_in(nrst_in), .pins_in(pins), .radio_in(radio), .fw_done_in(fw_done),
        .fw_oe_in(fw_oe), .fw_pull_in(fw_pull), .core_on_out(core_on),
        .core_rst_out(core_rst), .xo_stable_out(xo_ok), .seq_error_out(err),
        .state_out(state), .pad_oe_out(oe), .pad_ie_out(ie), .pad_pull_out(pull));
    // Compare one result
    task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Bounded wait for a state
    task automatic await(logic [5:0] s);
        for (int i = 0; i < SC + 20 && state !== s; i++) @(negedge mclk_in);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic t_up();
        up = 1'b1;
        repeat (4) @(negedge mclk_in);
        cmp("por", 8'h02, {2'h0, state});
        cmp("por_pads", 8'hff, pull & ~(oe | ie));
        await(6'h04);
        cmp("dflt", 8'h04, {2'h0, state});
        cmp("dflt_pads", 8'hff, ie & pull & ~oe);
        cmp("xo_err", 8'h02, {6'h0, xo_ok, err});
        $display("power_up done");
    endtask
    task automatic t_radio();
        logic [3:0] rv [5] = '{4'hc, 4'h4, 4'h2, 4'h1, 4'h0};
        logic [5:0] sv [5] = '{6'h10, 6'h20, 6'h10, 6'h20, 6'h08};
        fw_oe = 8'h0f;
        fw_pull = 8'h33;
        fw_done = 1'b1;
        await(6'h08);
        cmp("doze", 8'h08, {2'h0, state});
        cmp("fw_pads", 8'h0f, oe & ~ie);
        cmp("fw_pull", 8'h33, pull);
        foreach (rv[i]) begin
            radio = rv[i];
            repeat (2) @(negedge mclk_in);
            cmp("radio", {2'h0, sv[i]}, {2'h0, state});
        end
        cmp("core", 8'h02, {6'h0, core_on, core_rst});
        $display("radio done");
    endtask
    task automatic t_down();
        up = 1'b0;
        repeat (3) @(negedge mclk_in);
        cmp("off", 8'h01, {2'h0, state});
        cmp("off_pads", 8'h00, oe | ie | pull);
        cmp("off_core", 8'h00, {6'h0, core_on, err});
        $display("power_down done");
    endtask
    task automatic t_bad();
        bad = 1'b1;
        repeat (3) @(negedge mclk_in);
        cmp("bad_en", 8'h01, {6'h0, core_on, err});
        bad = 1'b0;
        $display("bad_enable done");
    endtask
    task automatic t_early();
        nrst_in = 1'b0;
        @(negedge mclk_in);
        cmp("rst_state", 8'h01, {2'h0, state});
        cmp("rst_core", 8'h00, {6'h0, core_on, err});
        nrst_in = 1'b1;
        early = 1'b1;
        up = 1'b1;
        await(6'h04);
        cmp("early_state", 8'h04, {2'h0, state});
        cmp("early_err", 8'h03, {6'h0, core_on, err});
        up = 1'b0;
        early = 1'b0;
        $display("early_release done");
    endtask
    // Clock
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    // Hang guard
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            mismatches++;
            conclude();
        end
    end
    // Main sequence
    initial begin
        {nrst_in, up, bad, early, fw_done, radio, fw_oe, fw_pull} = '0;
        repeat (16) @(negedge mclk_in);
        nrst_in = 1'b1;
        t_up();
        t_radio();
        t_down();
        t_bad();
        t_early();
        conclude();
    end
endmodule
